// ==== pkg/rtl_tlb_regs.vh ====
// Constants for the region-tagged translation lookaside buffer
`ifndef RTL_TLB_REGS_VH
`define RTL_TLB_REGS_VH
`define RTL_VA_W 64
`define RTL_SEL_HI 63
`define RTL_SEL_LO 61
`define RTL_SEL_W 3
`define RTL_NUM_REGIONS 8
`define RTL_RID_W_MIN 18
`define RTL_RID_W_MAX 24
`define RTL_RID_W_DEF 24
`define RTL_PAGE_SHIFT 12
`define RTL_ENTRIES 16
`define RTL_PPN_W 40
`define RTL_KEY_W 24
`define RTL_RID_RESET 24'h000000
`endif

// ==== hw/rtl_region_file.v ====
// Region register file: eight identifiers indexed by region select bits
`timescale 1ns/1ps
`include "rtl_tlb_regs.vh"
module rtl_region_file #(
  parameter RID_W = `RTL_RID_W_DEF
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire wr_en_i,
  input wire [`RTL_SEL_W-1:0] wr_sel_i,
  input wire [RID_W-1:0] wr_rid_i,
  input wire [`RTL_SEL_W-1:0] rd_sel_a_i,
  output wire [RID_W-1:0] rd_rid_a_o,
  input wire [`RTL_SEL_W-1:0] rd_sel_b_i,
  output wire [RID_W-1:0] rd_rid_b_o
);
  reg [RID_W-1:0] region_register_q [0:`RTL_NUM_REGIONS-1];
  integer i;
  // ****************************************
  // Storage
  // ****************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (i = 0; i < `RTL_NUM_REGIONS; i = i + 1) begin
        region_register_q[i] <= {RID_W{1'b0}};
      end
    end else if (wr_en_i) begin
      region_register_q[wr_sel_i] <= wr_rid_i;
    end
  end
  // Select bits only pick a register, nothing more
  assign rd_rid_a_o = region_register_q[rd_sel_a_i];
  assign rd_rid_b_o = region_register_q[rd_sel_b_i];
endmodule

// ==== hw/rtl_tlb.v ====
// Region-tagged TLB with lookup, insert and purge
// Summary of operation
// - 64-bit virtual space is eight equal regions of 2^61 bytes each.
// - Eight region registers, each holding that region's identifier.
// - Region identifier width is a parameter from 18 to 24 bits.
// - Address bits 63:61 index the region register giving the identifier.
// - Each entry stores identifier tag bits compared on lookup.
// - Hit only when identifier and page number both match an entry.
// - Region select bits never take part in the tag compare.
// - On insert, select bits only index a register; never stored.
// - Purge uses select bits for identifier; matches identifier and page only.
// - Same identifier in any region register reaches same translations.
// - Entries with different identifiers coexist; no flush on register change.
// - Each entry carries a protection key, output on a hit.
`timescale 1ns/1ps
`include "rtl_tlb_regs.vh"
module rtl_tlb #(
  parameter RID_W = `RTL_RID_W_DEF,
  parameter ENTRIES = `RTL_ENTRIES,
  parameter IDX_W = 4,
  parameter PAGE_SHIFT = `RTL_PAGE_SHIFT,
  parameter PPN_W = `RTL_PPN_W,
  parameter KEY_W = `RTL_KEY_W
) (
  input wire clk_i,
  input wire rst_b_i,
  // Region register write port
  input wire rr_wr_i,
  input wire [`RTL_SEL_W-1:0] rr_sel_i,
  input wire [RID_W-1:0] rr_rid_i,
  // Lookup
  input wire lk_req_i,
  input wire [`RTL_VA_W-1:0] lk_va_i,
  output reg lk_valid_o,
  output reg lk_hit_o,
  output reg lk_miss_o,
  output reg [PPN_W-1:0] lk_ppn_o,
  output reg [KEY_W-1:0] lk_key_o,
  output reg [RID_W-1:0] lk_rid_o,
  // Insert, from software or page walker
  input wire ins_req_i,
  input wire [`RTL_VA_W-1:0] ins_va_i,
  input wire [PPN_W-1:0] ins_ppn_i,
  input wire [KEY_W-1:0] ins_key_i,
  // Purge
  input wire pg_req_i,
  input wire [`RTL_VA_W-1:0] pg_va_i,
  output reg pg_done_o,
  output reg [IDX_W:0] pg_count_o
);
  localparam VPN_W = `RTL_SEL_LO - PAGE_SHIFT;

  // ****************************************
  // Parameter checks
  // ****************************************
  // A width outside the legal range makes a negative replication count,
  // so elaboration stops instead of building a mis-sized tag
  localparam [0:0] RID_W_OK =
    {((RID_W >= `RTL_RID_W_MIN) && (RID_W <= `RTL_RID_W_MAX) ? 1 : -1)
    {1'b1}};

  // ****************************************
  // Address field and tag functions
  // ****************************************
  // Top three bits name one of eight 2^61-byte regions
  function [`RTL_SEL_W-1:0] sel_of;
    input [`RTL_VA_W-1:0] va;
    begin
      sel_of = va[`RTL_SEL_HI:`RTL_SEL_LO];
    end
  endfunction

  // Page number stops below bit 61, so select bits stay out of the tag
  function [VPN_W-1:0] vpn_of;
    input [`RTL_VA_W-1:0] va;
    begin
      vpn_of = va[`RTL_SEL_LO-1:PAGE_SHIFT];
    end
  endfunction

  // One tag rule shared by lookup, insert and purge
  function tag_match;
    input valid;
    input [RID_W-1:0] ent_rid;
    input [VPN_W-1:0] ent_vpn;
    input [RID_W-1:0] req_rid;
    input [VPN_W-1:0] req_vpn;
    begin
      tag_match = valid && (ent_rid == req_rid) &&
        (ent_vpn == req_vpn);
    end
  endfunction

  // ****************************************
  // Entry storage
  // ****************************************
  reg ent_v_q [0:ENTRIES-1];
  reg [RID_W-1:0] ent_rid_q [0:ENTRIES-1];
  reg [VPN_W-1:0] ent_vpn_q [0:ENTRIES-1];
  reg [PPN_W-1:0] ent_ppn_q [0:ENTRIES-1];
  reg [KEY_W-1:0] ent_key_q [0:ENTRIES-1];
  reg [IDX_W-1:0] repl_q;

  // ****************************************
  // Region select
  // ****************************************
  wire [RID_W-1:0] lk_rid;
  wire [RID_W-1:0] side_rid;
  wire [`RTL_VA_W-1:0] side_va;
  wire [`RTL_SEL_W-1:0] lk_sel;
  wire [`RTL_SEL_W-1:0] side_sel;

  // Insert and purge share one port; purge first when both arrive
  assign side_va = pg_req_i ? pg_va_i : ins_va_i;
  assign lk_sel = sel_of(lk_va_i);
  assign side_sel = sel_of(side_va);

  // ****************************************
  // Region registers
  // ****************************************
  rtl_region_file #(
    .RID_W(RID_W)
  ) u_region_file (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .wr_en_i(rr_wr_i),
    .wr_sel_i(rr_sel_i),
    .wr_rid_i(rr_rid_i),
    .rd_sel_a_i(lk_sel),
    .rd_rid_a_o(lk_rid),
    .rd_sel_b_i(side_sel),
    .rd_rid_b_o(side_rid)
  );

  // ****************************************
  // Lookup compare
  // ****************************************
  reg hit;
  reg [IDX_W-1:0] hit_idx;
  reg [VPN_W-1:0] lk_vpn;
  integer k;
  always @* begin
    hit = 1'b0;
    hit_idx = {IDX_W{1'b0}};
    lk_vpn = vpn_of(lk_va_i);
    for (k = 0; k < ENTRIES; k = k + 1) begin
      // Tag is identifier plus page number only; any region reaches it
      if (!hit && tag_match(ent_v_q[k], ent_rid_q[k], ent_vpn_q[k],
          lk_rid, lk_vpn)) begin
        hit = 1'b1;
        hit_idx = k[IDX_W-1:0];
      end
    end
  end

  // ****************************************
  // Lookup answer
  // ****************************************
  reg lk_valid_d;
  reg lk_hit_d;
  reg lk_miss_d;
  reg [PPN_W-1:0] lk_ppn_d;
  reg [KEY_W-1:0] lk_key_d;
  reg [RID_W-1:0] lk_rid_d;
  always @* begin
    lk_valid_d = lk_req_i;
    lk_hit_d = lk_req_i & hit;
    lk_miss_d = lk_req_i & ~hit;
    // Data words hold the last answer between requests
    lk_ppn_d = lk_ppn_o;
    lk_key_d = lk_key_o;
    lk_rid_d = lk_rid_o;
    if (lk_req_i) begin
      lk_rid_d = lk_rid;
      if (hit) begin
        lk_ppn_d = ent_ppn_q[hit_idx];
        lk_key_d = ent_key_q[hit_idx];
      end else begin
        // Zero on a miss so a stale frame number never leaks out
        lk_ppn_d = {PPN_W{1'b0}};
        lk_key_d = {KEY_W{1'b0}};
      end
    end
  end

  // Handshake flags
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_valid_o <= 1'b0;
      lk_hit_o <= 1'b0;
      lk_miss_o <= 1'b0;
    end else begin
      lk_valid_o <= lk_valid_d;
      lk_hit_o <= lk_hit_d;
      lk_miss_o <= lk_miss_d;
    end
  end

  // Data words
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lk_ppn_o <= {PPN_W{1'b0}};
      lk_key_o <= {KEY_W{1'b0}};
      lk_rid_o <= {RID_W{1'b0}};
    end else begin
      lk_ppn_o <= lk_ppn_d;
      lk_key_o <= lk_key_d;
      lk_rid_o <= lk_rid_d;
    end
  end

  // ****************************************
  // Tag search for insert and purge
  // ****************************************
  reg [VPN_W-1:0] side_vpn;
  reg [IDX_W:0] purge_n;
  reg [ENTRIES-1:0] purge_m;
  integer p;
  always @* begin
    side_vpn = vpn_of(side_va);
    purge_n = {(IDX_W+1){1'b0}};
    purge_m = {ENTRIES{1'b0}};
    for (p = 0; p < ENTRIES; p = p + 1) begin
      if (tag_match(ent_v_q[p], ent_rid_q[p], ent_vpn_q[p],
          side_rid, side_vpn)) begin
        purge_m[p] = 1'b1;
        purge_n = purge_n + {{IDX_W{1'b0}}, 1'b1};
      end
    end
  end

  // ****************************************
  // Update decode
  // ****************************************
  reg pg_take;
  reg ins_take;
  reg [ENTRIES-1:0] clr_m;
  reg [IDX_W-1:0] repl_d;
  always @* begin
    // Purge wins a tie; the insert of that cycle is dropped
    pg_take = pg_req_i;
    ins_take = ins_req_i & ~pg_req_i;
    // Clearing an older copy of the same tag keeps lookups single-hit
    clr_m = (pg_take | ins_take) ? purge_m : {ENTRIES{1'b0}};
    repl_d = repl_q;
    if (ins_take) begin
      // Round-robin victim, whatever identifier it holds; only same-tag copies are cleared
      repl_d = repl_q + {{(IDX_W-1){1'b0}}, 1'b1};
    end
  end

  // ****************************************
  // Entry update
  // ****************************************
  integer j;
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (j = 0; j < ENTRIES; j = j + 1) begin
        ent_v_q[j] <= 1'b0;
        ent_rid_q[j] <= {RID_W{1'b0}};
        ent_vpn_q[j] <= {VPN_W{1'b0}};
        ent_ppn_q[j] <= {PPN_W{1'b0}};
        ent_key_q[j] <= {KEY_W{1'b0}};
      end
    end else begin
      for (j = 0; j < ENTRIES; j = j + 1) begin
        if (clr_m[j]) begin
          ent_v_q[j] <= 1'b0;
        end
      end
      // The set comes after the clear, so a reused slot stays valid
      if (ins_take) begin
        ent_v_q[repl_q] <= 1'b1;
        ent_rid_q[repl_q] <= side_rid;
        ent_vpn_q[repl_q] <= side_vpn;
        ent_ppn_q[repl_q] <= ins_ppn_i;
        ent_key_q[repl_q] <= ins_key_i;
      end
    end
  end

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      repl_q <= {IDX_W{1'b0}};
    end else begin
      repl_q <= repl_d;
    end
  end

  // ****************************************
  // Purge answer
  // ****************************************
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pg_done_o <= 1'b0;
      pg_count_o <= {(IDX_W+1){1'b0}};
    end else begin
      pg_done_o <= pg_take;
      if (pg_take) begin
        pg_count_o <= purge_n;
      end
    end
  end
endmodule

// ==== testbench/rtl_tlb_asserts.sv ====
// Port checker for the region-tagged TLB
`timescale 1ns/1ps
module rtl_tlb_asserts (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic lk_req_i,
  input wire logic lk_valid_o,
  input wire logic lk_hit_o,
  input wire logic lk_miss_o,
  input wire logic pg_req_i,
  input wire logic pg_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_ans; lk_valid_o ##0 (lk_hit_o ^ lk_miss_o); endsequence
  sequence s_two; lk_req_i ##1 lk_req_i; endsequence
  property p_ans; lk_req_i |=> s_ans; endproperty
  property p_quiet; !lk_req_i |=> !lk_valid_o; endproperty
  property p_hit; lk_hit_o |-> lk_valid_o; endproperty
  property p_miss; lk_miss_o |-> lk_valid_o; endproperty
  property p_back; s_two |-> lk_valid_o ##1 lk_valid_o; endproperty
  property p_pg; pg_req_i |=> pg_done_o; endproperty
  property p_pgq; !pg_req_i |=> !pg_done_o; endproperty
  property p_pgl; pg_done_o |-> ##1 !pg_done_o || $past(pg_req_i); endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  a_quiet: assert property (p_quiet) else $error("stray answer");
  a_hit: assert property (p_hit) else $error("hit alone");
  a_miss: assert property (p_miss) else $error("miss alone");
  a_back: assert property (p_back) else $error("lost lookup");
  a_pg: assert property (p_pg) else $error("no purge done");
  a_pgq: assert property (p_pgq) else $error("stray purge done");
  a_pgl: assert property (p_pgl) else $error("purge done held");
endmodule
bind rtl_tlb rtl_tlb_asserts u_rtl_tlb_asserts (.clk_i, .rst_b_i, .lk_req_i,
  .lk_valid_o, .lk_hit_o, .lk_miss_o, .pg_req_i, .pg_done_o);

// ==== testbench/rtl_tlb_req_model.sv ====
// Requester model for the lookup port of the TLB
`timescale 1ns/1ps
module rtl_tlb_req_model (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [63:0] va_i,
  output logic req_o,
  output logic [63:0] va_o
);
  // Idle address flips each cycle so a stale value never looks held
  initial req_o = 1'h0;
  initial va_o = 64'h0;
  always @(posedge clk_i) begin
    req_o <= go_i;
    va_o <= go_i ? va_i : ~va_o;
  end
endmodule

// ==== testbench/tb_top.sv ====
// Self-checking testbench for the region-tagged TLB
`timescale 1ns/1ps
module tb_top;
  logic clk_i = 0, rst_b_i = 0, go_i = 0;
  logic rr_wr_i = 0, ins_req_i = 0, pg_req_i = 0;
  logic [2:0] rr_sel_i = 0;
  logic [23:0] rr_rid_i = 0, ins_key_i = 0, lk_key_o, lk_rid_o;
  logic [39:0] ins_ppn_i = 0, lk_ppn_o;
  logic [63:0] va_i = 0, lk_va_i, ins_va_i = 0, pg_va_i = 0;
  logic lk_req_i, lk_valid_o, lk_hit_o, lk_miss_o, pg_done_o;
  logic [4:0] pg_count_o;
  int miscompares = 0, samples_checked = 0, cyc = 0;
  localparam logic [23:0] RA = 24'h0000A1, RB = 24'h0000B2;
  localparam logic [39:0] PA = 40'h00000ABCDE, PB = 40'h0000012345;
  localparam logic [48:0] VX = 49'h00000001234;
  always #10 clk_i = ~clk_i;
  rtl_tlb_req_model u_rtl_tlb_req_model (.clk_i, .go_i, .va_i,
    .req_o(lk_req_i), .va_o(lk_va_i));
  rtl_tlb u_rtl_tlb (.clk_i, .rst_b_i, .rr_wr_i, .rr_sel_i, .rr_rid_i,
    .lk_req_i, .lk_va_i, .lk_valid_o, .lk_hit_o, .lk_miss_o, .lk_ppn_o,
    .lk_key_o, .lk_rid_o, .ins_req_i, .ins_va_i, .ins_ppn_i, .ins_key_i,
    .pg_req_i, .pg_va_i, .pg_done_o, .pg_count_o);
  function automatic logic [63:0] mk(input logic [2:0] s, input logic [48:0] v);
    return {s, v, 12'h000};
  endfunction
  task automatic chk(input logic [63:0] s, e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_sim;
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rr(input logic [2:0] s, input logic [23:0] r);
    @(posedge clk_i);
    rr_wr_i <= 1'h1;
    rr_sel_i <= s;
    rr_rid_i <= r;
    @(posedge clk_i);
    rr_wr_i <= 1'h0;
  endtask
  task automatic ins(input logic [63:0] v, input logic [39:0] p);
    @(posedge clk_i);
    ins_req_i <= 1'h1;
    ins_va_i <= v;
    ins_ppn_i <= p;
    ins_key_i <= p[23:0];
    @(posedge clk_i);
    ins_req_i <= 1'h0;
  endtask
  task automatic pg(input logic [63:0] v, input logic [4:0] n);
    @(posedge clk_i);
    pg_req_i <= 1'h1;
    pg_va_i <= v;
    @(posedge clk_i);
    pg_req_i <= 1'h0;
    @(negedge clk_i);
    chk(pg_done_o, 1'h1);
    chk(pg_count_o, n);
  endtask
  // Lookup goes through the requester model, so the answer lags two edges
  task automatic lk(input logic [63:0] v, input logic [39:0] p,
      input logic [23:0] r);
    @(posedge clk_i);
    go_i <= 1'h1;
    va_i <= v;
    @(posedge clk_i);
    go_i <= 1'h0;
    @(posedge clk_i);
    @(negedge clk_i);
    chk(lk_hit_o, p != 40'h0);
    chk(lk_miss_o, p == 40'h0);
    chk(lk_ppn_o, p);
    chk(lk_key_o, p[23:0]);
    chk(lk_rid_o, r);
  endtask
  task automatic t_alias;
    lk(mk(3'h3, VX), 40'h0, 24'h0);
    rr(3'h1, RA);
    rr(3'h5, RA);
    rr(3'h2, RB);
    ins(mk(3'h1, VX), PA);
    lk(mk(3'h5, VX), PA, RA);
    lk(mk(3'h2, VX), 40'h0, RB);
    lk(mk(3'h1, VX + 49'h1), 40'h0, RA);
    rr(3'h5, RB);
    ins(mk(3'h5, VX), PB);
    lk(mk(3'h1, VX), PA, RA);
    lk(mk(3'h2, VX), PB, RB);
  endtask
  task automatic t_purge;
    pg(mk(3'h2, VX), 5'h01);
    lk(mk(3'h5, VX), 40'h0, RB);
    lk(mk(3'h1, VX), PA, RA);
    pg(mk(3'h5, VX), 5'h00);
  endtask
  task automatic t_dup;
    ins(mk(3'h1, VX), PB);
    lk(mk(3'h1, VX), PB, RA);
    pg(mk(3'h1, VX), 5'h01);
    lk(mk(3'h1, VX), 40'h0, RA);
  endtask
  task automatic t_regions;
    for (int i = 0; i < 8; i++) rr(i[2:0], 24'h000100 + 24'(i));
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      go_i <= (i < 8);
      va_i <= mk(i[2:0], 49'h0);
      @(negedge clk_i);
      if (i >= 2) begin
        chk(lk_valid_o, 1'h1);
        chk(lk_rid_o, 24'h000100 + 24'(i - 2));
      end
    end
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_b_i <= 1'h1;
    t_alias();
    t_purge();
    t_dup();
    t_regions();
    end_sim();
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      miscompares++;
      end_sim();
    end
  end
endmodule
